/* inc/decoder_defines.svh */
// Purpose: shared constants of the 12-bit instruction executor
// Assumes: pclk is the oscillator; APB byte addresses on paddr[7:0]
// Notes: file window holds 32 byte registers, one per aligned word
//
// Function
// RL1: 0001_11 adds, 0000_10 subtracts W from f; all three flags; one cycle.
// RL2: destination bit 0 sends result to W, 1 back to the file register.
// RL3: 0001_01 AND, 0001_00 OR, 0001_10 XOR of W and f; Z only.
// RL4: 0011_01 rotates left, 0011_00 right through carry; only C changes.
// RL5: 0010_11 decrement, 0011_11 increment; zero result skips next, two cycles.
// RL6: 0100 clears, 0101 sets bit b of file f; one cycle, no flags.
// RL7: 0110 skips if bit clear, 0111 if set; skip takes two cycles.
// RL8: 1110/1101/1111 AND/OR/XOR literal into W with Z; 1100 loads literal.
// RL9: 1001 call, 101 branch, 1000 return with literal; two cycles, no flags.
// RL10: any PC write except the branch forces PC bit 8 to zero; code lets return load all nine stack bits.
// RL11: 0x003 standby, 0x004 watchdog clear; update timeout and powerdown.
// RL12: tristate load with f=6 copies W to tristate latches; 0010 loads option.
// RL13: read-modify-write of the port uses pin levels, not the output latch.
// RL14: file write to the timer clears the prescaler when assigned to timer; code skips the clear for complement.
// RL15: one instruction cycle is four oscillator periods; two when PC changes.
// RL16: also decode clear, complement, inc, dec, move, swap and no-operation.
`ifndef DECODER_DEFINES_SVH
`define DECODER_DEFINES_SVH

`define OSC_PER_INSTR 4

`define REG_INSTR 8'h00
`define REG_STAT 8'h04
`define REG_WORK 8'h08
`define REG_PC 8'h0C
`define REG_OPTION 8'h10
`define REG_TRISTATE 8'h14
`define FILE_WIN_BIT 7

`define F_TIMER 5'h01
`define F_PCL 5'h02
`define F_STATUS 5'h03
`define F_PORT 5'h06
`define TRISTATE_PORT_SEL 3'h6

`define ST_C 0
`define ST_DIG_CARRY 1
`define ST_Z 2
`define ST_PWR_DOWN 3
`define ST_TIME_OUT 4
`define ST_UP_LSB 5
`define STAT_BUSY 8
`define STAT_SLEEP 9
`define STAT_SKIP 10
`define OPT_PSA 3
`define OPC_D_BIT 5
`define OPC_BIT_LSB 5

`define STATUS_RST 8'h18
`define OPTION_RST 8'hFF
`define TRISTATE_RST 8'hFF
`define WORK_RST 8'h00
`define PORT_RST 8'h00
`define PC_RST 9'h000

`endif

/* inc/decoder_pkg.sv */
// Purpose: types shared by the executor and its arithmetic unit
// Assumes: nothing beyond SystemVerilog
// Notes: state codes are one-hot
package decoder_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SKIP = 3'b100
	} exec_state_t;

	typedef enum logic [5:0] {
		OP_NOP, OP_MOVWF, OP_CLRW, OP_CLRF, OP_SUB, OP_DEC, OP_IOR,
		OP_AND, OP_XOR, OP_ADD, OP_MOVF, OP_COMF, OP_INC, OP_DECSZ,
		OP_ROT_RIGHT, OP_ROT_LEFT, OP_SWAP, OP_INCSZ, OP_BIT_CLR,
		OP_BIT_SET, OP_TEST_CLR, OP_TEST_SET, OP_OPTION, OP_SLEEP,
		OP_WDOG_CLR, OP_TRI_LOAD, OP_RET_LIT, OP_CALL, OP_BRANCH,
		OP_MOVL, OP_IORL, OP_ANDL, OP_XORL
	} alu_op_t;
endpackage

/* design/alu8.sv */
// Purpose: 8-bit result and carry logic for one decoded instruction
// Assumes: operands are stable for the whole instruction cycle
// Notes: purely combinational
`timescale 1ns/1ps
module alu8
	import decoder_pkg::*;
(
	input wire alu_op_t op,
	input wire logic [7:0] f_val,
	input wire logic [7:0] w_val,
	input wire logic [7:0] lit,
	input wire logic [2:0] bit_sel,
	input wire logic c_in,
	output logic [7:0] res,
	output logic c_out,
	output logic dc_out,
	output logic bit_val
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	assign mask = 8'h01 << bit_sel;
	assign bit_val = |(f_val & mask);

	always_comb begin
		sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
		nib = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
		res = f_val;
		c_out = c_in;
		dc_out = 1'b0;
		case (op)
			OP_ADD: begin
				sum = {1'b0, f_val} + {1'b0, w_val}; // RL1
				nib = {1'b0, f_val[3:0]} + {1'b0, w_val[3:0]};
				res = sum[7:0];
				c_out = sum[8];
				dc_out = nib[4];
			end
			OP_SUB: begin
				// carry set means no borrow
				res = sum[7:0]; // RL1
				c_out = sum[8];
				dc_out = nib[4];
			end
			OP_AND: res = f_val & w_val; // RL3
			OP_IOR: res = f_val | w_val; // RL3
			OP_XOR: res = f_val ^ w_val; // RL3
			OP_ANDL: res = w_val & lit; // RL8
			OP_IORL: res = w_val | lit; // RL8
			OP_XORL: res = w_val ^ lit; // RL8
			OP_MOVL, OP_RET_LIT: res = lit; // RL8
			OP_COMF: res = ~f_val; // RL16
			OP_DEC, OP_DECSZ: res = f_val - 8'h01; // RL16
			OP_INC, OP_INCSZ: res = f_val + 8'h01; // RL16
			OP_ROT_LEFT: begin
				res = {f_val[6:0], c_in}; // RL4
				c_out = f_val[7];
			end
			OP_ROT_RIGHT: begin
				res = {c_in, f_val[7:1]}; // RL4
				c_out = f_val[0];
			end
			OP_SWAP: res = {f_val[3:0], f_val[7:4]}; // RL16
			OP_BIT_CLR: res = f_val & ~mask; // RL6
			OP_BIT_SET: res = f_val | mask; // RL6
			OP_CLRF, OP_CLRW: res = 8'h00; // RL16
			OP_MOVWF: res = w_val; // RL16
			default: res = f_val;
		endcase
	end
endmodule

/* design/instr_exec.sv */
// Purpose: executes 12-bit instruction words written over APB
// Assumes: APB master holds request until pready; pins are asynchronous
// Notes: zero-wait APB with registered answer; one instruction at a time
`timescale 1ns/1ps
`include "decoder_defines.svh"
module instr_exec
	import decoder_pkg::*;
#(
	parameter int OSC_DIV = `OSC_PER_INSTR
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pins_in,
	output logic [7:0] port_out,
	output logic [7:0] port_tristate,
	output logic [7:0] option_out,
	output logic prescaler_clear,
	output logic wdt_clear,
	output logic sleeping
);
	localparam int DIV_W = (OSC_DIV > 2) ? $clog2(OSC_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

	exec_state_t state_ff, nxt_state;
	logic [DIV_W-1:0] div_ff;
	logic [11:0] instr_ff;
	logic [7:0] work_ff, status_ff, option_ff, tristate_ff, port_ff;
	logic [8:0] pc_ff, stack0_ff, stack1_ff, nxt_pc;
	logic [7:0] mem [0:31];
	logic [7:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_val_ff;
	logic [7:0] pin_agree, nxt_pin_val;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic presc_clr_ff, wdt_clr_ff, sleeping_ff, skip_ff;
	logic [7:0] nxt_status;

	// pins: three stages, a level counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_ff <= 8'h00;
			pin_s2_ff <= 8'h00;
			pin_s3_ff <= 8'h00;
			pin_val_ff <= 8'h00;
		end else begin
			pin_s1_ff <= pins_in;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_val_ff <= nxt_pin_val;
		end
	end
	assign pin_agree = ~(pin_s2_ff ^ pin_s3_ff);
	assign nxt_pin_val = (pin_s2_ff & pin_agree) | (pin_val_ff & ~pin_agree);

	// decode
	function automatic alu_op_t decode(input logic [11:0] i);
		casez (i)
			12'b0000_0000_0000: decode = OP_NOP;
			12'b0000_0000_0010: decode = OP_OPTION;
			12'b0000_0000_0011: decode = OP_SLEEP;
			12'b0000_0000_0100: decode = OP_WDOG_CLR;
			12'b0000_0000_0???: decode = OP_TRI_LOAD;
			12'b0000_001?_????: decode = OP_MOVWF;
			12'b0000_010?_????: decode = OP_CLRW;
			12'b0000_011?_????: decode = OP_CLRF;
			12'b0000_10??_????: decode = OP_SUB;
			12'b0000_11??_????: decode = OP_DEC;
			12'b0001_00??_????: decode = OP_IOR;
			12'b0001_01??_????: decode = OP_AND;
			12'b0001_10??_????: decode = OP_XOR;
			12'b0001_11??_????: decode = OP_ADD;
			12'b0010_00??_????: decode = OP_MOVF;
			12'b0010_01??_????: decode = OP_COMF;
			12'b0010_10??_????: decode = OP_INC;
			12'b0010_11??_????: decode = OP_DECSZ;
			12'b0011_00??_????: decode = OP_ROT_RIGHT;
			12'b0011_01??_????: decode = OP_ROT_LEFT;
			12'b0011_10??_????: decode = OP_SWAP;
			12'b0011_11??_????: decode = OP_INCSZ;
			12'b0100_????_????: decode = OP_BIT_CLR;
			12'b0101_????_????: decode = OP_BIT_SET;
			12'b0110_????_????: decode = OP_TEST_CLR;
			12'b0111_????_????: decode = OP_TEST_SET;
			12'b1000_????_????: decode = OP_RET_LIT;
			12'b1001_????_????: decode = OP_CALL;
			12'b101?_????_????: decode = OP_BRANCH;
			12'b1100_????_????: decode = OP_MOVL;
			12'b1101_????_????: decode = OP_IORL;
			12'b1110_????_????: decode = OP_ANDL;
			12'b1111_????_????: decode = OP_XORL;
			default: decode = OP_NOP;
		endcase
	endfunction

	// special locations are views of live state; the port reads pins
	function automatic logic [7:0] file_read(input logic [4:0] a,
		input logic [7:0] mv);
		case (a)
			`F_PCL: file_read = pc_ff[7:0];
			`F_STATUS: file_read = status_ff;
			`F_PORT: file_read = pin_val_ff; // RL13
			default: file_read = mv;
		endcase
	endfunction

	alu_op_t op;
	logic [4:0] f_addr;
	logic [7:0] f_val, alu_res;
	logic alu_c, alu_dc, alu_bit;
	logic has_d, dest_file, wr_file, wr_w, upd_z, upd_cdc, upd_c;
	logic skip_take, two_cycle, res_zero;

	assign op = decode(instr_ff);
	assign f_addr = instr_ff[4:0];
	assign f_val = file_read(f_addr, mem[f_addr]);
	assign dest_file = instr_ff[`OPC_D_BIT];
	assign res_zero = alu_res == 8'h00;

	alu8 u_alu (
		.op(op),
		.f_val(f_val),
		.w_val(work_ff),
		.lit(instr_ff[7:0]),
		.bit_sel(instr_ff[`OPC_BIT_LSB +: 3]),
		.c_in(status_ff[`ST_C]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.bit_val(alu_bit)
	);

	assign has_d = op inside {OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
		OP_ADD, OP_MOVF, OP_COMF, OP_INC, OP_DECSZ, OP_ROT_RIGHT, OP_ROT_LEFT,
		OP_SWAP, OP_INCSZ};
	assign wr_file = (has_d & dest_file) | // RL2
		(op inside {OP_MOVWF, OP_CLRF, OP_BIT_CLR, OP_BIT_SET}); // RL6
	assign wr_w = (has_d & ~dest_file) | // RL2
		(op inside {OP_CLRW, OP_MOVL, OP_IORL, OP_ANDL, OP_XORL,
		OP_RET_LIT}); // RL8
	assign upd_z = op inside {OP_AND, OP_IOR, OP_XOR, OP_ADD, OP_SUB,
		OP_CLRF, OP_CLRW, OP_COMF, OP_DEC, OP_INC, OP_MOVF, OP_ANDL,
		OP_IORL, OP_XORL}; // RL3
	assign upd_cdc = op inside {OP_ADD, OP_SUB}; // RL1
	assign upd_c = op inside {OP_ROT_LEFT, OP_ROT_RIGHT}; // RL4
	assign skip_take = ((op inside {OP_DECSZ, OP_INCSZ}) & res_zero) | // RL5
		((op == OP_TEST_CLR) & ~alu_bit) | ((op == OP_TEST_SET) & alu_bit); // RL7
	assign two_cycle = skip_take | // RL15
		(op inside {OP_CALL, OP_BRANCH, OP_RET_LIT}) | // RL9
		(wr_file & (f_addr == `F_PCL));

	// instruction cycle divider, restarted by each new instruction
	logic tick, commit, idle, start;
	assign tick = div_ff == DIV_LAST; // RL15
	assign idle = state_ff == ST_IDLE;
	assign commit = (state_ff == ST_EXEC) & tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_ff <= '0;
		else if (start || tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + 1'b1;
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (start) nxt_state = ST_EXEC;
			ST_EXEC: if (tick) nxt_state = two_cycle ? ST_SKIP : ST_IDLE;
			ST_SKIP: if (tick) nxt_state = ST_IDLE; // RL15
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// apb decode; answer is registered in the setup cycle
	logic apb_setup, wr_acc, hit, writable, refuse;
	logic sel_instr, sel_stat, sel_work, sel_pc, sel_opt, sel_tristate;
	logic sel_file;
	logic [31:0] rd_val;
	assign apb_setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_ff & pwrite & ~pslverr_ff;
	assign sel_instr = paddr == `REG_INSTR;
	assign sel_stat = paddr == `REG_STAT;
	assign sel_work = paddr == `REG_WORK;
	assign sel_pc = paddr == `REG_PC;
	assign sel_opt = paddr == `REG_OPTION;
	assign sel_tristate = paddr == `REG_TRISTATE;
	assign sel_file = paddr[`FILE_WIN_BIT] & (paddr[1:0] == 2'b00);
	assign hit = sel_instr | sel_stat | sel_work | sel_pc | sel_opt |
		sel_tristate | sel_file;
	assign writable = sel_instr | sel_work | sel_pc | sel_file;
	// a busy executor refuses state writes rather than racing them
	assign refuse = ~hit | (pwrite & writable & ~idle);
	assign start = wr_acc & sel_instr;
	assign rd_val = sel_instr ? {20'h0_0000, instr_ff} :
		sel_stat ? {21'h00_0000, skip_ff, sleeping_ff, ~idle, status_ff} :
		sel_work ? {24'h00_0000, work_ff} :
		sel_pc ? {23'h00_0000, pc_ff} :
		sel_opt ? {24'h00_0000, option_ff} :
		sel_tristate ? {24'h00_0000, tristate_ff} :
		sel_file ? {24'h00_0000, file_read(paddr[6:2], mem[paddr[6:2]])} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & refuse;
			prdata_ff <= (apb_setup & ~pwrite & hit) ? rd_val : 32'h0000_0000;
		end
	end

	// shared file write port: executor or idle-time software
	logic fw_en, pcl_wr, apb_file_wr;
	logic [4:0] fw_addr;
	logic [7:0] fw_data;
	assign apb_file_wr = wr_acc & sel_file;
	assign fw_en = (commit & wr_file) | apb_file_wr; // RL2
	assign fw_addr = commit ? f_addr : paddr[6:2];
	assign fw_data = commit ? alu_res : pwdata[7:0];
	assign pcl_wr = fw_en & (fw_addr == `F_PCL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++)
				mem[i] <= 8'h00;
		end else if (fw_en) begin
			mem[fw_addr] <= fw_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			port_ff <= `PORT_RST;
		else if (fw_en && fw_addr == `F_PORT)
			port_ff <= fw_data;
	end

	// program counter and two-level return stack
	assign nxt_pc = !commit ? ((wr_acc & sel_pc) ? pwdata[8:0] :
		pcl_wr ? {1'b0, fw_data} : pc_ff) : // RL10
		(op == OP_BRANCH) ? instr_ff[8:0] : // RL9
		(op == OP_CALL) ? {1'b0, instr_ff[7:0]} : // RL10
		(op == OP_RET_LIT) ? stack0_ff : // RL9
		pcl_wr ? {1'b0, alu_res} : // RL10
		skip_take ? pc_ff + 9'h002 : pc_ff + 9'h001; // RL5

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff <= `PC_RST;
			stack0_ff <= `PC_RST;
			stack1_ff <= `PC_RST;
		end else begin
			pc_ff <= nxt_pc;
			if (commit && op == OP_CALL) begin
				stack1_ff <= stack0_ff; // RL9
				stack0_ff <= pc_ff + 9'h001;
			end else if (commit && op == OP_RET_LIT) begin
				stack0_ff <= stack1_ff; // RL9
			end
		end
	end

	// status: a direct write lands first, instruction flags override it
	always_comb begin
		nxt_status = status_ff;
		if (fw_en && fw_addr == `F_STATUS) begin
			nxt_status[7:`ST_UP_LSB] = fw_data[7:`ST_UP_LSB];
			nxt_status[`ST_Z] = fw_data[`ST_Z];
			nxt_status[`ST_DIG_CARRY] = fw_data[`ST_DIG_CARRY];
			nxt_status[`ST_C] = fw_data[`ST_C];
		end
		if (commit) begin
			if (upd_z)
				nxt_status[`ST_Z] = res_zero; // RL3
			if (upd_cdc) begin
				nxt_status[`ST_C] = alu_c; // RL1
				nxt_status[`ST_DIG_CARRY] = alu_dc;
			end
			if (upd_c)
				nxt_status[`ST_C] = alu_c; // RL4
			if (op == OP_WDOG_CLR) begin
				nxt_status[`ST_TIME_OUT] = 1'b1; // RL11
				nxt_status[`ST_PWR_DOWN] = 1'b1;
			end
			if (op == OP_SLEEP) begin
				nxt_status[`ST_TIME_OUT] = 1'b1; // RL11
				nxt_status[`ST_PWR_DOWN] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_ff <= `STATUS_RST;
		else
			status_ff <= nxt_status;
	end

	// working, option and tristate registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_ff <= `WORK_RST;
			option_ff <= `OPTION_RST;
			tristate_ff <= `TRISTATE_RST;
		end else begin
			if (commit && wr_w)
				work_ff <= alu_res; // RL2
			else if (wr_acc && sel_work)
				work_ff <= pwdata[7:0];
			if (commit && op == OP_OPTION)
				option_ff <= work_ff; // RL12
			if (commit && op == OP_TRI_LOAD &&
				instr_ff[2:0] == `TRISTATE_PORT_SEL)
				tristate_ff <= work_ff; // RL12
		end
	end

	// instruction latch, side pulses and standby
	logic presc_hit;
	// complement is the one file op that leaves the prescaler alone
	assign presc_hit = commit & wr_file & (f_addr == `F_TIMER) &
		(op != OP_COMF) & ~option_ff[`OPT_PSA]; // RL14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ff <= 12'h000;
			presc_clr_ff <= 1'b0;
			wdt_clr_ff <= 1'b0;
			sleeping_ff <= 1'b0;
			skip_ff <= 1'b0;
		end else begin
			if (start)
				instr_ff <= pwdata[11:0];
			presc_clr_ff <= presc_hit; // RL14
			wdt_clr_ff <= commit & (op inside {OP_WDOG_CLR, OP_SLEEP}); // RL11
			if (start)
				sleeping_ff <= 1'b0;
			else if (commit && op == OP_SLEEP)
				sleeping_ff <= 1'b1; // RL11
			if (commit)
				skip_ff <= skip_take; // RL7
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign port_out = port_ff;
	assign port_tristate = tristate_ff;
	assign option_out = option_ff;
	assign prescaler_clear = presc_clr_ff;
	assign wdt_clear = wdt_clr_ff;
	assign sleeping = sleeping_ff;
endmodule

/* test/instr_exec_asserts.sv */
// Purpose: port-level timing checks for the instruction executor
// Assumes: results commit four edges after the accepted INSTR write
// Notes: bound to instr_exec; one clock domain
`timescale 1ns/1ps
module exec_checker #(
	parameter int OSC_DIV = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] port_tristate,
	input wire logic [7:0] option_out,
	input wire logic prescaler_clear,
	input wire logic wdt_clear,
	input wire logic sleeping
);
	wire setup = psel && !penable;
	// only a write the slave accepted starts an instruction
	wire wr_instr = psel && penable && pready && pwrite &&
		paddr == 8'h00 && !pslverr;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_one: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_cause: assert property (pready |-> $past(setup))
		else $error("pready without setup");
	chk_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 0)
		else $error("refused read not clean");
	chk_wdt_cause: assert property (wdt_clear |-> $past(wr_instr, 5))
		else $error("watchdog clear not after commit");
	chk_wdt_pulse: assert property (wdt_clear |=> !wdt_clear)
		else $error("watchdog clear too long");
	chk_pre_cause: assert property (prescaler_clear |-> $past(wr_instr, 5))
		else $error("prescaler clear not after commit");
	chk_pre_pulse: assert property (prescaler_clear |=> !prescaler_clear)
		else $error("prescaler clear too long");
	chk_latch_cause: assert property ($changed(port_tristate) ||
		$changed(option_out) |-> $past(wr_instr, 5))
		else $error("latch moved without instruction");
	chk_sleep_cause: assert property ($rose(sleeping) |-> $past(wr_instr, 5))
		else $error("standby without instruction");
	chk_sleep_wake: assert property (sleeping && wr_instr |-> ##[1:5] !sleeping)
		else $error("standby not left");
	cov_instr: cover property (wr_instr);
	cov_refused: cover property (pslverr);
	cov_sleep: cover property ($rose(sleeping));
	cov_pre: cover property (prescaler_clear);
endmodule

bind instr_exec exec_checker #(.OSC_DIV(OSC_DIV)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_tristate(port_tristate), .option_out(option_out),
	.prescaler_clear(prescaler_clear), .wdt_clear(wdt_clear),
	.sleeping(sleeping));

/* test/tb_top.sv */
// Purpose: self-checking bench for the instruction executor
// Assumes: file register 8 is plain storage at byte 0xA0
// Notes: busy polls per instruction: 1 for one cycle, 3 for two
`timescale 1ns/1ps
`include "decoder_defines.svh"
module tb_top;
	typedef struct packed {
		logic [7:0] w, f;
		logic [2:0] st;
		logic [11:0] op;
		logic [7:0] ew, ef;
		logic [2:0] est;
	} row_t;
	typedef struct packed {
		logic [11:0] op;
		logic [7:0] f;
		logic sk;
	} skip_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, prescaler_clear, wdt_clear;
	logic sleeping, err;
	logic [7:0] paddr = 8'h00, pins_in = 8'h00;
	logic [7:0] port_out, port_tristate, option_out;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int num_errors = 0, n_tests = 0, np, n_pre = 0, m, n_wdt = 0;
	row_t rows [22] = '{
		'{8'h0f,8'h01,3'h0,12'h1e8,8'h0f,8'h10,3'h2},
		'{8'h80,8'h80,3'h0,12'h1c8,8'h00,8'h80,3'h5},
		'{8'h05,8'h05,3'h0,12'h0a8,8'h05,8'h00,3'h7},
		'{8'h02,8'h01,3'h0,12'h088,8'hff,8'h01,3'h0},
		'{8'hf0,8'h0f,3'h1,12'h148,8'h00,8'h0f,3'h5},
		'{8'h0f,8'hf0,3'h0,12'h128,8'h0f,8'hff,3'h0},
		'{8'haa,8'haa,3'h2,12'h188,8'h00,8'haa,3'h6},
		'{8'h00,8'h81,3'h4,12'h368,8'h00,8'h02,3'h5},
		'{8'h00,8'h01,3'h1,12'h308,8'h80,8'h01,3'h1},
		'{8'h00,8'hff,3'h0,12'h468,8'h00,8'hf7,3'h0},
		'{8'h00,8'h00,3'h7,12'h5e8,8'h00,8'h80,3'h7},
		'{8'hf0,8'h00,3'h0,12'he0f,8'h00,8'h00,3'h4},
		'{8'h00,8'h00,3'h4,12'hd01,8'h01,8'h00,3'h0},
		'{8'hff,8'h00,3'h0,12'hfff,8'h00,8'h00,3'h4},
		'{8'h00,8'h00,3'h7,12'hc5a,8'h5a,8'h00,3'h7},
		'{8'h00,8'h33,3'h0,12'h068,8'h00,8'h00,3'h4},
		'{8'h33,8'h00,3'h0,12'h040,8'h00,8'h00,3'h4},
		'{8'h00,8'h0f,3'h0,12'h268,8'h00,8'hf0,3'h0},
		'{8'h00,8'h01,3'h0,12'h0c8,8'h00,8'h01,3'h4},
		'{8'h00,8'hff,3'h1,12'h2a8,8'h00,8'h00,3'h5},
		'{8'h3c,8'h00,3'h7,12'h028,8'h3c,8'h3c,3'h7},
		'{8'h00,8'h12,3'h0,12'h3a8,8'h00,8'h21,3'h0}};
	skip_t skips [6] = '{'{12'h2e8,8'h01,1'b1}, '{12'h3e8,8'hff,1'b1},
		'{12'h3e8,8'h01,1'b0}, '{12'h608,8'hfe,1'b1},
		'{12'h608,8'h01,1'b0}, '{12'h7e8,8'h80,1'b1}};
	instr_exec #(.OSC_DIV(4)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_in(pins_in), .port_out(port_out),
		.port_tristate(port_tristate), .option_out(option_out),
		.prescaler_clear(prescaler_clear), .wdt_clear(wdt_clear),
		.sleeping(sleeping));
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) if (prescaler_clear === 1'b1) n_pre <= n_pre + 1;
	always @(posedge pclk) if (wdt_clear === 1'b1) n_wdt <= n_wdt + 1;
	task automatic end_of_test();
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic exec(input logic [11:0] op);
		apb(1'b1, `REG_INSTR, {20'h0_0000, op});
		np = 0;
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		while (rd[`STAT_BUSY] === 1'b1) begin
			np++;
			apb(1'b0, `REG_STAT, 32'h0000_0000);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, a, {24'h00_0000, v});
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`REG_STAT, 32'h0000_0018);
		rdchk(`REG_TRISTATE, 32'h0000_00ff);
		rdchk(`REG_OPTION, 32'h0000_00ff);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		apb(1'b0, 8'h81, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		foreach (rows[i]) begin
			wreg(`REG_WORK, rows[i].w);
			wreg(8'ha0, rows[i].f);
			wreg(8'h8c, {5'h00, rows[i].st});
			exec(rows[i].op);
			chk(32'(np), 32'h0000_0001);
			chk(32'(rd[2:0]), 32'(rows[i].est));
			rdchk(`REG_WORK, 32'(rows[i].ew));
			rdchk(8'ha0, 32'(rows[i].ef));
		end
		foreach (skips[i]) begin
			wreg(8'ha0, skips[i].f);
			wreg(8'h8c, 8'h00);
			exec(skips[i].op);
			chk(32'(np), skips[i].sk ? 32'h3 : 32'h1);
			chk(32'(rd[`STAT_SKIP]), 32'(skips[i].sk));
			chk(32'(rd[2:0]), 32'h0000_0000);
		end
		exec(12'hbff);
		chk(32'(np), 32'h0000_0003);
		rdchk(`REG_PC, 32'h0000_01ff);
		wreg(`REG_WORK, 8'h40);
		exec(12'h022);
		chk(32'(np), 32'h0000_0003);
		rdchk(`REG_PC, 32'h0000_0040);
		apb(1'b1, `REG_PC, 32'h0000_0010);
		exec(12'h9ab);
		chk(32'(np), 32'h0000_0003);
		rdchk(`REG_PC, 32'h0000_00ab);
		exec(12'h877);
		chk(32'(np), 32'h0000_0003);
		rdchk(`REG_WORK, 32'h0000_0077);
		rdchk(`REG_PC, 32'h0000_0011);
		// second word is refused while the first is still executing
		apb(1'b1, `REG_INSTR, 32'h0000_0000);
		apb(1'b1, `REG_INSTR, 32'h0000_0c55);
		chk(32'(err), 32'h0000_0001);
		repeat (12) @(posedge pclk);
		rdchk(`REG_WORK, 32'h0000_0077);
		m = n_wdt;
		exec(12'h003);
		chk(32'(n_wdt - m), 32'h0000_0001);
		chk(32'(rd[4:3]), 32'h0000_0002);
		chk(32'(sleeping), 32'h0000_0001);
		exec(12'h004);
		chk(32'(n_wdt - m), 32'h0000_0002);
		chk(32'(rd[4:3]), 32'h0000_0003);
		chk(32'(sleeping), 32'h0000_0000);
		wreg(`REG_WORK, 8'h07);
		exec(12'h002);
		chk(32'(option_out), 32'h0000_0007);
		wreg(`REG_WORK, 8'h0f);
		exec(12'h006);
		chk(32'(port_tristate), 32'h0000_000f);
		wreg(`REG_WORK, 8'h00);
		exec(12'h005);
		chk(32'(port_tristate), 32'h0000_000f);
		m = n_pre;
		exec(12'h2a1);
		chk(32'(n_pre - m), 32'h0000_0001);
		exec(12'h281);
		chk(32'(n_pre - m), 32'h0000_0001);
		wreg(8'h98, 8'hff);
		pins_in <= 8'h5a;
		repeat (8) @(posedge pclk);
		exec(12'h226);
		chk(32'(port_out), 32'h0000_005a);
		end_of_test();
	end
endmodule
